// file: core/tps_top.sv
// trip path supervision: sense decode, debounce, alarms, APB registers
// How it works
// - each circuit selects one or two sense inputs, with matching evaluation
// - sense routing not matching the mode raises a per-circuit routing fault
// - one independent supervision instance per breaker pole
// - two inputs decode to closed, open, tripped or disturbance
// - only both inputs low counts as abnormal
// - both inputs sampled every 500 ms
// - failure alarm after three consecutive abnormal samples
// - alarm clears automatically after the same time of normal samples
// - one input: high is intact, low expected only while trip contact closed
// - one input continuously low reports a failure
// - evaluation and alarms suspended during a system fault
// - a momentary low on the single input raises no alarm
// - single input alarm delayed by the configurable alarm delay
// - two inputs also decode breaker position via auxiliary contact; status shows circuit 0 only
// - alarm delay ranges 1 to 30 s, default 2 s
// - global on/off defaults off; off asserts a status output
// - inputs per circuit selects one or two, default two
`timescale 1ns/1ns
module tps_top #(
    parameter int CIRCUITS = 3,
    parameter int SAMPLE_CYCLES = tps_pkg::SAMPLE_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire tps_pkg::tps_sense_type [CIRCUITS-1:0] sense_i,
    input wire logic [CIRCUITS-1:0] first_routed_i,
    input wire logic [CIRCUITS-1:0] second_routed_i,
    input wire logic system_fault_i,
    output logic [CIRCUITS-1:0] trip_fail_o,
    output logic [CIRCUITS-1:0] routing_fault_alarm_o,
    output logic supervision_off_o,
    output logic irq_o
);
    localparam int CW = 7;
    localparam int LAST = CIRCUITS - 1;
    // ==================================================
    // input synchronisers
    logic [CIRCUITS-1:0] s1a, s2a, s1b, s2b;
    logic flt_a, flt_b;
    // routing pins are static in use but still asynchronous
    logic [CIRCUITS-1:0] r1a, r1b, r2a, r2b;
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < CIRCUITS; i++) begin
            s1a[i] <= sense_i[i].first_sense_input;
            s2a[i] <= sense_i[i].second_sense_input;
        end
        s1b <= s1a;
        s2b <= s2a;
        flt_a <= system_fault_i;
        flt_b <= flt_a;
        r1a <= first_routed_i;
        r1b <= r1a;
        r2a <= second_routed_i;
        r2b <= r2a;
    end
    // ==================================================
    // registers
    logic supervision_on_off;
    logic [CIRCUITS-1:0] inputs_per_circuit;
    logic [4:0] alarm_delay_s;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    wire wr_en = psel_i & penable_i & pwrite_i;
    wire hit_ctrl = paddr_i == tps_pkg::ADDR_CTRL;
    wire hit_delay = paddr_i == tps_pkg::ADDR_DELAY;
    wire hit_status = paddr_i == tps_pkg::ADDR_STATUS;
    wire hit_stat = paddr_i == tps_pkg::ADDR_IRQ_STAT;
    wire hit_mask = paddr_i == tps_pkg::ADDR_IRQ_MASK;
    wire hit_any = hit_ctrl | hit_delay | hit_status | hit_stat | hit_mask;
    wire [4:0] wr_delay = pwdata_i[4:0];
    wire [4:0] next_delay = (wr_delay < tps_pkg::DELAY_MIN_S) ? tps_pkg::DELAY_MIN_S :
        (wr_delay > tps_pkg::DELAY_MAX_S) ? tps_pkg::DELAY_MAX_S : wr_delay;
    // ==================================================
    // sample tick
    // divider restarts on reset, so the first sample lands one interval later
    logic [$clog2(SAMPLE_CYCLES)-1:0] tick_cnt;
    logic tick;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else if (tick_cnt == ($clog2(SAMPLE_CYCLES))'(SAMPLE_CYCLES - 1)) begin
            tick_cnt <= '0;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick <= 1'b0;
        end
    end
    // ==================================================
    // per-circuit supervision
    logic [CIRCUITS-1:0] fail;
    logic [CIRCUITS-1:0] route_bad;
    logic [CIRCUITS-1:0] fail_rise, route_rise;
    tps_pkg::tps_state_type pos_state [CIRCUITS];
    wire active = supervision_on_off & ~flt_b;
    // one-input delay counted in samples, so it moves in 500 ms steps
    wire [CW-1:0] one_limit = CW'(alarm_delay_s) * CW'(tps_pkg::SAMPLES_PER_S);
    function automatic tps_pkg::tps_state_type decode(input logic a, input logic b);
        case ({a, b})
            2'b10: decode = tps_pkg::TPS_CLOSED;
            2'b11: decode = tps_pkg::TPS_OPEN;
            2'b01: decode = tps_pkg::TPS_TRIPPED;
            default: decode = tps_pkg::TPS_DISTURB;
        endcase
    endfunction
    genvar g;
    for (g = 0; g < CIRCUITS; g++) begin : g_circ
        logic [CW-1:0] bad_cnt, good_cnt;
        // mode select, two is bit zero
        wire two = ~inputs_per_circuit[g];
        // decode pair; second input reflects auxiliary contact
        wire tps_pkg::tps_state_type st = decode(s1b[g], s2b[g]);
        // only both-low abnormal; single input low abnormal
        wire abn = two ? (st == tps_pkg::TPS_DISTURB) : ~s1b[g];
        wire [CW-1:0] lim = two ? CW'(tps_pkg::ABN_SAMPLES) : one_limit;
        wire rbad = ~r1b[g] | (two & ~r2b[g]);
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                bad_cnt <= '0;
                good_cnt <= '0;
                fail[g] <= 1'b0;
                route_bad[g] <= 1'b0;
                pos_state[g] <= tps_pkg::TPS_OPEN;
            end else begin
                // routing judged only while supervision is on
                route_bad[g] <= rbad & supervision_on_off;
                // a fault only freezes the alarm; off or bad routing drops it
                // hold evaluation during faults
                if (!active || rbad) begin
                    bad_cnt <= '0;
                    good_cnt <= '0;
                    if (!supervision_on_off || rbad)
                        fail[g] <= 1'b0;
                end else if (tick) begin
                    pos_state[g] <= st;
                    if (abn) begin
                        good_cnt <= '0;
                        if (bad_cnt < lim)
                            bad_cnt <= bad_cnt + 1'b1;
                        if (bad_cnt + 1'b1 >= lim)
                            fail[g] <= 1'b1;
                    end else begin
                        bad_cnt <= '0;
                        if (good_cnt < lim)
                            good_cnt <= good_cnt + 1'b1;
                        if (good_cnt + 1'b1 >= lim)
                            fail[g] <= 1'b0;
                    end
                end
            end
        end
    end
    // ==================================================
    // outputs, interrupt status and APB
    logic [CIRCUITS-1:0] fail_q, route_q;
    assign fail_rise = fail & ~fail_q;
    assign route_rise = route_bad & ~route_q;
    // off event fires once, on the cycle after switch-off
    wire [2:0] ev = {~supervision_on_off & ~supervision_off_o, |route_rise, |fail_rise};
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        if (hit_ctrl) begin
            rdata[tps_pkg::CTRL_ON_BIT] = supervision_on_off;
            rdata[tps_pkg::CTRL_MODE_LSB +: CIRCUITS] = inputs_per_circuit;
        end else if (hit_delay) begin
            rdata[4:0] = alarm_delay_s;
        end else if (hit_status) begin
            rdata[CIRCUITS-1:0] = fail;
            rdata[8 +: CIRCUITS] = route_bad;
            rdata[16] = ~supervision_on_off;
            rdata[17] = flt_b;
            rdata[24 +: 4] = pos_state[0];
        end else if (hit_stat) begin
            rdata[2:0] = irq_stat;
        end else if (hit_mask) begin
            rdata[2:0] = irq_mask;
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            supervision_on_off <= tps_pkg::CTRL_RESET[tps_pkg::CTRL_ON_BIT];
            inputs_per_circuit <= '0;
            alarm_delay_s <= tps_pkg::DELAY_RESET_S;
            irq_stat <= 3'h0;
            irq_mask <= 3'h0;
            fail_q <= '0;
            route_q <= '0;
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            trip_fail_o <= '0;
            routing_fault_alarm_o <= '0;
            supervision_off_o <= 1'b1;
            irq_o <= 1'b0;
        end else begin
            fail_q <= fail;
            route_q <= route_bad;
            trip_fail_o <= fail;
            routing_fault_alarm_o <= route_bad;
            supervision_off_o <= ~supervision_on_off;
            // level interrupt, one cycle behind its status
            irq_o <= |(irq_stat & irq_mask);
            // zero-wait slave: answers in the first access cycle
            pready_o <= psel_i & ~pready_o;
            pslverr_o <= psel_i & ~pready_o & ~hit_any;
            prdata_o <= rdata;
            if (wr_en && pready_o && hit_ctrl) begin
                supervision_on_off <= pwdata_i[tps_pkg::CTRL_ON_BIT];
                inputs_per_circuit <= pwdata_i[tps_pkg::CTRL_MODE_LSB +: CIRCUITS];
            end
            if (wr_en && pready_o && hit_delay)
                alarm_delay_s <= next_delay;
            if (wr_en && pready_o && hit_mask)
                irq_mask <= pwdata_i[2:0];
            // set wins over write-one-to-clear
            irq_stat <= (irq_stat & ~((wr_en && pready_o && hit_stat) ? pwdata_i[2:0] : 3'h0))
                | ev;
        end
    end
    // ==================================================
    // checks
    property p_off_status;
        @(posedge clk_i) disable iff (reset_i)
        !supervision_on_off |=> supervision_off_o;
    endproperty
    a_off_status: assert property (p_off_status) else $error("off status missing");
    property p_fault_hold;
        @(posedge clk_i) disable iff (reset_i)
        flt_b && supervision_on_off |=> $stable(fail);
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fail moved in fault");
    property p_two_count;
        @(posedge clk_i) disable iff (reset_i)
        active && tick && !inputs_per_circuit[0] && !g_circ[0].rbad &&
        g_circ[0].bad_cnt == 7'd2 && g_circ[0].abn |=> fail[0];
    endproperty
    a_two_count: assert property (p_two_count) else $error("no alarm after three");
    property p_healthy_reset;
        @(posedge clk_i) disable iff (reset_i)
        active && tick && !g_circ[0].rbad && !g_circ[0].abn |=> g_circ[0].bad_cnt == 7'd0;
    endproperty
    a_healthy_reset: assert property (p_healthy_reset) else $error("count not cleared");
    property p_delay_range;
        @(posedge clk_i) disable iff (reset_i)
        alarm_delay_s >= 5'd1 && alarm_delay_s <= 5'd30;
    endproperty
    a_delay_range: assert property (p_delay_range) else $error("delay out of range");
    property p_route;
        @(posedge clk_i) disable iff (reset_i)
        supervision_on_off && !r1b[0] |=> route_bad[0];
    endproperty
    a_route: assert property (p_route) else $error("routing fault missing");
    property p_tick;
        @(posedge clk_i) disable iff (reset_i)
        tick |=> !tick;
    endproperty
    a_tick: assert property (p_tick) else $error("tick too long");
    property p_abn_two;
        @(posedge clk_i) disable iff (reset_i)
        !inputs_per_circuit[0] && (s1b[0] || s2b[0]) |-> !g_circ[0].abn;
    endproperty
    a_abn_two: assert property (p_abn_two) else $error("healthy seen abnormal");
    // output registers follow their internal sources by one cycle
    property p_fail_out;
        @(posedge clk_i) disable iff (reset_i)
        1'b1 |=> trip_fail_o == $past(fail);
    endproperty
    a_fail_out: assert property (p_fail_out) else $error("alarm output wrong");
    property p_route_out;
        @(posedge clk_i) disable iff (reset_i)
        1'b1 |=> routing_fault_alarm_o == $past(route_bad);
    endproperty
    a_route_out: assert property (p_route_out) else $error("routing output wrong");
    property p_route_clear;
        @(posedge clk_i) disable iff (reset_i)
        supervision_on_off && !g_circ[0].rbad |=> !route_bad[0];
    endproperty
    a_route_clear: assert property (p_route_clear) else $error("routing fault stuck");
    property p_off_clears;
        @(posedge clk_i) disable iff (reset_i)
        !supervision_on_off |=> fail == '0;
    endproperty
    a_off_clears: assert property (p_off_clears) else $error("alarm while off");
    property p_off_route;
        @(posedge clk_i) disable iff (reset_i)
        !supervision_on_off |=> route_bad == '0;
    endproperty
    a_off_route: assert property (p_off_route) else $error("routing fault while off");
    property p_fault_count;
        @(posedge clk_i) disable iff (reset_i)
        flt_b |=> g_circ[0].bad_cnt == 7'd0 && g_circ[0].good_cnt == 7'd0;
    endproperty
    a_fault_count: assert property (p_fault_count) else $error("counted in fault");
    property p_two_clear;
        @(posedge clk_i) disable iff (reset_i)
        active && tick && !inputs_per_circuit[0] && !g_circ[0].rbad && !g_circ[0].abn &&
        g_circ[0].good_cnt == 7'd2 |=> !fail[0];
    endproperty
    a_two_clear: assert property (p_two_clear) else $error("alarm not cleared");
    property p_two_good_reset;
        @(posedge clk_i) disable iff (reset_i)
        active && tick && !g_circ[0].rbad && g_circ[0].abn |=> g_circ[0].good_cnt == 7'd0;
    endproperty
    a_two_good_reset: assert property (p_two_good_reset) else $error("good count kept");
    property p_one_count;
        @(posedge clk_i) disable iff (reset_i)
        active && tick && inputs_per_circuit[LAST] && !g_circ[LAST].rbad && g_circ[LAST].abn &&
        g_circ[LAST].bad_cnt == one_limit - 7'd1 |=> fail[LAST];
    endproperty
    a_one_count: assert property (p_one_count) else $error("no alarm after delay");
    property p_one_quiet;
        @(posedge clk_i) disable iff (reset_i)
        inputs_per_circuit[LAST] && !fail[LAST] && g_circ[LAST].bad_cnt == 7'd0 |=> !fail[LAST];
    endproperty
    a_one_quiet: assert property (p_one_quiet) else $error("alarm on momentary low");
    property p_one_low;
        @(posedge clk_i) disable iff (reset_i)
        inputs_per_circuit[LAST] && !s1b[LAST] |-> g_circ[LAST].abn;
    endproperty
    a_one_low: assert property (p_one_low) else $error("low input not abnormal");
    property p_one_high;
        @(posedge clk_i) disable iff (reset_i)
        inputs_per_circuit[LAST] && s1b[LAST] |-> !g_circ[LAST].abn;
    endproperty
    a_one_high: assert property (p_one_high) else $error("high input abnormal");
endmodule // tps_top

// file: core/tps_pkg.sv
// package for the trip path supervision block
package tps_pkg;
    // ==================================================
    // register map (byte addresses)
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_DELAY = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;
    // ==================================================
    // field positions and reset values
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_MODE_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [4:0] DELAY_MIN_S = 5'h01;
    localparam logic [4:0] DELAY_MAX_S = 5'h1E;
    localparam logic [4:0] DELAY_RESET_S = 5'h02;
    // ==================================================
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int SAMPLE_MS = 500;
    localparam int SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_MS;
    localparam int ABN_SAMPLES = 3;
    localparam int SAMPLES_PER_S = 1000 / SAMPLE_MS;
    // ==================================================
    // per-circuit decode of the sense pair
    typedef struct packed {
        logic first_sense_input;
        logic second_sense_input;
    } tps_sense_type;
    typedef enum logic [3:0] {
        TPS_CLOSED = 4'h1,
        TPS_OPEN = 4'h2,
        TPS_TRIPPED = 4'h4,
        TPS_DISTURB = 4'h8
    } tps_state_type;
endpackage

// file: test/tps_partner.sv
// breaker, trip contact and control voltage model driving the sense pairs
`timescale 1ns/1ns
module tps_partner #(
    parameter int CIRCUITS = 3,
    parameter int OPEN_CYCLES = 3
) (
    input wire logic clk_i,
    input wire logic [CIRCUITS-1:0] trip_cmd_i,
    input wire logic [CIRCUITS-1:0] close_i,
    input wire logic [CIRCUITS-1:0] break_i,
    output tps_pkg::tps_sense_type [CIRCUITS-1:0] sense_o
);
    logic [CIRCUITS-1:0] closed = '1;
    // no command in flight at start, else the breaker state goes unknown
    logic [CIRCUITS-1:0] cmd_d [OPEN_CYCLES] = '{default: '0};
    // ==================================================
    // breaker mechanism: opens some cycles after the trip command
    always_ff @(posedge clk_i) begin
        cmd_d[0] <= trip_cmd_i;
        for (int k = 1; k < OPEN_CYCLES; k++) begin
            cmd_d[k] <= cmd_d[k-1];
        end
        closed <= (closed & ~cmd_d[OPEN_CYCLES-1]) | (close_i & ~trip_cmd_i);
    end
    // ==================================================
    // closed contact shorts its sense input; a broken path kills both
    always_comb begin
        for (int c = 0; c < CIRCUITS; c++) begin
            sense_o[c].first_sense_input = ~trip_cmd_i[c] & ~break_i[c];
            sense_o[c].second_sense_input = ~closed[c] & ~break_i[c];
        end
    end
endmodule // tps_partner

// file: test/tb.sv
// self-checking bench for the trip path supervision block
`timescale 1ns/1ns
module tb;
    localparam int NC = 3;
    localparam int SC = 20;
    logic clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic er, system_fault = 1'h0;
    logic [NC-1:0] cmd = 3'h0, cls = 3'h0, brk = 3'h0, rt1 = 3'h7, rt2 = 3'h7;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, supervision_off_o, irq_o;
    logic [NC-1:0] trip_fail_o, routing_fault_alarm_o;
    tps_pkg::tps_sense_type [NC-1:0] sense;
    int num_errors = 0;
    int comparisons = 0;
    always #25 clk_i = ~clk_i;
    tps_partner #(.CIRCUITS(NC)) tps_partner_i (.clk_i(clk_i), .trip_cmd_i(cmd),
        .close_i(cls), .break_i(brk), .sense_o(sense));
    tps_top #(.CIRCUITS(NC), .SAMPLE_CYCLES(SC)) tps_top_i (.clk_i(clk_i), .reset_i(reset_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .sense_i(sense), .first_routed_i(rt1), .second_routed_i(rt2),
        .system_fault_i(system_fault), .trip_fail_o(trip_fail_o),
        .routing_fault_alarm_o(routing_fault_alarm_o),
        .supervision_off_o(supervision_off_o), .irq_o(irq_o));
    // ==================================================
    // shared tasks
    task end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD at %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'h1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'h1 && n < 20);
        rd = prdata_o;
        er = pslverr_o;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 20) begin
            num_errors++;
            end_of_test();
        end
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd & m, exp);
    endtask
    function logic pick(input int s, input int c);
        return (s == 0) ? trip_fail_o[c] : routing_fault_alarm_o[c];
    endfunction
    // bounded wait for an alarm level, then compare
    task expect_out(input int s, input int c, input logic v, input int lim);
        for (int n = 0; n < lim && pick(s, c) !== v; n++) begin
            @(posedge clk_i);
        end
        chk(pick(s, c), v);
    endtask
    task hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // ==================================================
    // main sequence
    initial begin
        hold(2);
        reset_i <= 1'h0;
        rdc(tps_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
        rdc(tps_pkg::ADDR_DELAY, 32'h1F, 32'h2);
        rdc(tps_pkg::ADDR_STATUS, 32'h10000, 32'h10000);
        chk(supervision_off_o, 1'h1);
        apb(1'h0, 12'h040, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'h1, tps_pkg::ADDR_DELAY, 32'h0);
        rdc(tps_pkg::ADDR_DELAY, 32'h1F, 32'h1);
        apb(1'h1, tps_pkg::ADDR_DELAY, 32'h1F);
        rdc(tps_pkg::ADDR_DELAY, 32'h1F, 32'h1E);
        apb(1'h1, tps_pkg::ADDR_CTRL, 32'h1);
        apb(1'h1, tps_pkg::ADDR_IRQ_STAT, 32'h7);
        hold(2 * SC);
        rdc(tps_pkg::ADDR_STATUS, 32'h0F010707, 32'h01000000);
        cmd[0] <= 1'h1;
        hold(2 * SC);
        rdc(tps_pkg::ADDR_STATUS, 32'h0F000001, 32'h04000000);
        cmd[0] <= 1'h0;
        hold(2 * SC);
        rdc(tps_pkg::ADDR_STATUS, 32'h0F000001, 32'h02000000);
        cls[0] <= 1'h1;
        hold(2 * SC);
        rdc(tps_pkg::ADDR_STATUS, 32'h0F000001, 32'h01000000);
        // short outages with healthy gaps between never alarm
        repeat (3) begin
            brk[1] <= 1'h1;
            hold(2 * SC - 8);
            brk[1] <= 1'h0;
            hold(SC + SC / 2);
        end
        chk(trip_fail_o[1], 1'h0);
        brk[0] <= 1'h1;
        hold(2 * SC - 5);
        chk(trip_fail_o[0], 1'h0);
        expect_out(0, 0, 1'h1, SC + 15);
        rdc(tps_pkg::ADDR_STATUS, 32'h0F000001, 32'h08000001);
        rdc(tps_pkg::ADDR_IRQ_STAT, 32'h1, 32'h1);
        chk(irq_o, 1'h0);
        apb(1'h1, tps_pkg::ADDR_IRQ_MASK, 32'h1);
        hold(2);
        chk(irq_o, 1'h1);
        apb(1'h1, tps_pkg::ADDR_IRQ_STAT, 32'h1);
        hold(2);
        chk(irq_o, 1'h0);
        brk[0] <= 1'h0;
        hold(2 * SC - 5);
        chk(trip_fail_o[0], 1'h1);
        expect_out(0, 0, 1'h0, SC + 15);
        system_fault <= 1'h1;
        brk[1] <= 1'h1;
        hold(5 * SC);
        chk(trip_fail_o[1], 1'h0);
        brk[1] <= 1'h0;
        system_fault <= 1'h0;
        rt2[1] <= 1'h0;
        expect_out(1, 1, 1'h1, 10);
        chk(routing_fault_alarm_o, 3'h2);
        rt2[1] <= 1'h1;
        expect_out(1, 1, 1'h0, 10);
        rt1[0] <= 1'h0;
        expect_out(1, 0, 1'h1, 10);
        chk(routing_fault_alarm_o, 3'h1);
        rt1[0] <= 1'h1;
        expect_out(1, 0, 1'h0, 10);
        apb(1'h1, tps_pkg::ADDR_DELAY, 32'h1);
        apb(1'h1, tps_pkg::ADDR_CTRL, 32'h401);
        rt2[2] <= 1'h0;
        hold(4);
        chk(routing_fault_alarm_o, 3'h0);
        cmd[2] <= 1'h1;
        hold(SC / 2);
        cmd[2] <= 1'h0;
        cls[2] <= 1'h1;
        hold(3 * SC);
        chk(trip_fail_o[2], 1'h0);
        brk[2] <= 1'h1;
        hold(SC - 5);
        chk(trip_fail_o[2], 1'h0);
        expect_out(0, 2, 1'h1, SC + 15);
        chk(trip_fail_o[1:0], 2'h0);
        brk[2] <= 1'h0;
        expect_out(0, 2, 1'h0, 2 * SC + 15);
        apb(1'h1, tps_pkg::ADDR_CTRL, 32'h0);
        rdc(tps_pkg::ADDR_STATUS, 32'h10000, 32'h10000);
        chk(supervision_off_o, 1'h1);
        end_of_test();
    end
endmodule // tb
